/* rtl/bbd_pkg.sv */
// Overview of operation
// - start timer A when the host assigns the function's address
// - timer A expiry forces detach, then reattach as default device
// - start timer B when host requests the alternate-mode string
// - timer B expiry forces detach, then reattach as default device
// - each timer step is ten milliseconds
// - timeout is 16 bits in low/high byte registers, default 07d0h
// - descriptor bytes configurable, with documented defaults
// - active-low trigger input from the PD controller activates billboard
// - trigger detach and timers work only while control bit 0 is set; clearing it in billboard mode forces detach and default reattach
`default_nettype none
package bbd_pkg;
    localparam logic [15:0] TIMEOUT_A_LOW_OFS  = 16'h413c;
    localparam logic [15:0] TIMEOUT_A_HIGH_OFS = 16'h413d;
    localparam logic [15:0] TIMEOUT_B_LOW_OFS  = 16'h413e;
    localparam logic [15:0] TIMEOUT_B_HIGH_OFS = 16'h413f;
    localparam logic [15:0] CONTROL_OFS        = 16'h4140;
    localparam logic [15:0] STATUS_OFS         = 16'h4141;
    localparam logic [15:0] IRQ_STATUS_OFS     = 16'h4142;
    localparam logic [15:0] IRQ_MASK_OFS       = 16'h4143;
    localparam logic [15:0] DESC_BASE_OFS      = 16'h4150;
    localparam int          DESC_LEN           = 48;
    localparam logic [7:0]  TIMEOUT_LOW_RST    = 8'hd0;
    localparam logic [7:0]  TIMEOUT_HIGH_RST   = 8'h07;
    localparam logic [7:0]  CONTROL_RST        = 8'h14;
    localparam int          ENABLE_BIT         = 0;
    // descriptor defaults, index = byte within descriptor block
    localparam int          DESC_ADDL_URL      = 3;
    localparam int          DESC_NUM_MODES     = 4;
    localparam int          DESC_VCONN_HI      = 7;
    localparam int          DESC_VERSION_LO    = 40;
    localparam int          DESC_VERSION_HI    = 41;
    localparam int          DESC_SVID_HI       = 45;
    localparam logic [7:0]  ADDL_URL_RST       = 8'h01;
    localparam logic [7:0]  NUM_MODES_RST      = 8'h01;
    localparam logic [7:0]  VCONN_HI_RST       = 8'h80;
    localparam logic [7:0]  VERSION_LO_RST     = 8'h10;
    localparam logic [7:0]  VERSION_HI_RST     = 8'h01;
    localparam logic [7:0]  SVID_HI_RST        = 8'hff;
    // irq status bits
    localparam int          IRQ_TRIGGER        = 0;
    localparam int          IRQ_EXPIRE_A       = 1;
    localparam int          IRQ_EXPIRE_B       = 2;
    localparam int          IRQ_REATTACH       = 3;
    localparam int          CLK_MHZ            = 125;
    localparam int          STEP_MS            = 10;
    localparam int          STEP_CYCLES        = CLK_MHZ * 1000 * STEP_MS;
    localparam int          DETACH_MS          = 10;
    localparam int          DETACH_CYCLES      = CLK_MHZ * 1000 * DETACH_MS;
    typedef enum logic [2:0] {
        BBD_IDLE, BBD_DETACH_IN, BBD_BILLBOARD, BBD_DETACH_OUT, BBD_DEFAULT
    } bbd_mode_type;
endpackage
`default_nettype wire

/* rtl/bbd_sync.sv */
`default_nettype none
// three stages; a change counts once stages two and three agree
module bbd_sync (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic pinIn,
    output logic      levelOut
);
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } bbd_sync_type;
    bbd_sync_type st_r;
    bbd_sync_type st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.stage = {st_r.stage[1:0], pinIn};
        if (st_r.stage[1] == st_r.stage[2]) begin
            st_nxt.level = st_r.stage[2];
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '{stage: 3'h7, level: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign levelOut = st_r.level;
endmodule
`default_nettype wire

/* rtl/bbd_timer.sv */
`default_nettype none
// one detach timer: counts programmed steps of the shared step tick
module bbd_timer (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic        clear,
    input  wire logic        stepTick,
    input  wire logic [15:0] timeout,
    output logic             expired,
    output logic             running
);
    typedef struct packed {
        logic        run;
        logic [15:0] count;
        logic        fire;
    } bbd_timer_type;
    bbd_timer_type st_r;
    bbd_timer_type st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.fire = 1'b0;
        if (clear) begin
            st_nxt.run = 1'b0;
            st_nxt.count = 16'h0;
        end else if (start && !st_r.run) begin
            st_nxt.run = 1'b1;
            st_nxt.count = 16'h0;
        end else if (st_r.run && stepTick) begin
            // a zero timeout expires on the first step, not never
            if (st_r.count + 16'h1 >= timeout) begin
                st_nxt.fire = 1'b1;
                st_nxt.run = 1'b0;
            end
            st_nxt.count = st_r.count + 16'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign expired = st_r.fire;
    assign running = st_r.run;
endmodule
`default_nettype wire

/* rtl/bbd_detach_timers.sv */
`default_nettype none
module bbd_detach_timers #(
    parameter int STEP_CYCLES   = bbd_pkg::STEP_CYCLES,
    parameter int DETACH_CYCLES = bbd_pkg::DETACH_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [7:0]       regRdData,
    input  wire logic        triggerN,
    input  wire logic        addressSet,
    input  wire logic        altStringReq,
    output logic             connectOut,
    output logic             billboardMode,
    output logic             irqOut
);
    typedef struct packed {
        logic [7:0]                 rdData;
        logic [7:0]                 toALow;
        logic [7:0]                 toAHigh;
        logic [7:0]                 toBLow;
        logic [7:0]                 toBHigh;
        logic [7:0]                 control;
        logic [3:0]                 irqStat;
        logic [3:0]                 irqMask;
        logic [bbd_pkg::DESC_LEN-1:0][7:0] desc;
        bbd_pkg::bbd_mode_type      mode;
        logic [31:0]                stepCnt;
        logic                       stepTick;
        logic [31:0]                detCnt;
        logic                       connect;
        logic                       bbMode;
        logic                       irq;
    } bbd_top_type;

    bbd_top_type st_r;
    bbd_top_type st_nxt;
    bbd_top_type rstVal;
    logic        trigLevel;
    logic        expA;
    logic        expB;
    logic        runA;
    logic        runB;
    logic        inBillboard;
    logic        enabled;
    logic        clearTimers;

    bbd_sync u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pinIn   (triggerN),
        .levelOut(trigLevel)
    );

    assign enabled     = st_r.control[bbd_pkg::ENABLE_BIT];
    assign inBillboard = (st_r.mode == bbd_pkg::BBD_BILLBOARD);
    assign clearTimers = !inBillboard || !enabled || expA || expB;

    bbd_timer u_timer_a (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .start   (inBillboard && enabled && addressSet),
        .clear   (clearTimers),
        .stepTick(st_r.stepTick),
        .timeout ({st_r.toAHigh, st_r.toALow}),
        .expired (expA),
        .running (runA)
    );

    bbd_timer u_timer_b (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .start   (inBillboard && enabled && altStringReq),
        .clear   (clearTimers),
        .stepTick(st_r.stepTick),
        .timeout ({st_r.toBHigh, st_r.toBLow}),
        .expired (expB),
        .running (runB)
    );

    always_comb begin
        rstVal = '0;
        rstVal.toALow  = bbd_pkg::TIMEOUT_LOW_RST;
        rstVal.toAHigh = bbd_pkg::TIMEOUT_HIGH_RST;
        rstVal.toBLow  = bbd_pkg::TIMEOUT_LOW_RST;
        rstVal.toBHigh = bbd_pkg::TIMEOUT_HIGH_RST;
        rstVal.control = bbd_pkg::CONTROL_RST;
        rstVal.desc[bbd_pkg::DESC_ADDL_URL]   = bbd_pkg::ADDL_URL_RST;
        rstVal.desc[bbd_pkg::DESC_NUM_MODES]  = bbd_pkg::NUM_MODES_RST;
        rstVal.desc[bbd_pkg::DESC_VCONN_HI]   = bbd_pkg::VCONN_HI_RST;
        rstVal.desc[bbd_pkg::DESC_VERSION_LO] = bbd_pkg::VERSION_LO_RST;
        rstVal.desc[bbd_pkg::DESC_VERSION_HI] = bbd_pkg::VERSION_HI_RST;
        rstVal.desc[bbd_pkg::DESC_SVID_HI]    = bbd_pkg::SVID_HI_RST;
        rstVal.mode    = bbd_pkg::BBD_IDLE;
        rstVal.connect = 1'b1;
    end

    always_comb begin
        logic [3:0]  ev;
        logic [15:0] descIdx;
        ev = 4'h0;
        descIdx = regAddr - bbd_pkg::DESC_BASE_OFS;
        st_nxt = st_r;
        st_nxt.detCnt = st_r.detCnt;

        // shared 10 ms step divider, kept free-running so both timers tick together
        st_nxt.stepTick = 1'b0;
        if (st_r.stepCnt >= 32'(STEP_CYCLES - 1)) begin
            st_nxt.stepCnt  = 32'h0;
            st_nxt.stepTick = 1'b1;
        end else begin
            st_nxt.stepCnt = st_r.stepCnt + 32'h1;
        end

        unique case (st_r.mode)
            bbd_pkg::BBD_IDLE: begin
                if (enabled && !trigLevel) begin
                    st_nxt.mode    = bbd_pkg::BBD_DETACH_IN;
                    st_nxt.connect = 1'b0;
                    st_nxt.detCnt  = 32'h0;
                    ev[bbd_pkg::IRQ_TRIGGER] = 1'b1;
                end
            end
            bbd_pkg::BBD_DETACH_IN: begin
                if (st_r.detCnt >= 32'(DETACH_CYCLES - 1)) begin
                    st_nxt.mode    = bbd_pkg::BBD_BILLBOARD;
                    st_nxt.connect = 1'b1;
                    st_nxt.bbMode  = 1'b1;
                end else begin
                    st_nxt.detCnt = st_r.detCnt + 32'h1;
                end
            end
            bbd_pkg::BBD_BILLBOARD: begin
                if (!enabled) begin
                    st_nxt.mode = bbd_pkg::BBD_DETACH_OUT;
                    st_nxt.connect = 1'b0;
                    st_nxt.detCnt = 32'h0;
                end else if (expA || expB) begin
                    st_nxt.mode    = bbd_pkg::BBD_DETACH_OUT;
                    st_nxt.connect = 1'b0;
                    st_nxt.detCnt  = 32'h0;
                    ev[bbd_pkg::IRQ_EXPIRE_A] = expA;
                    ev[bbd_pkg::IRQ_EXPIRE_B] = expB;
                end
            end
            bbd_pkg::BBD_DETACH_OUT: begin
                if (st_r.detCnt >= 32'(DETACH_CYCLES - 1)) begin
                    st_nxt.mode    = bbd_pkg::BBD_DEFAULT;
                    st_nxt.connect = 1'b1;
                    st_nxt.bbMode  = 1'b0;
                    ev[bbd_pkg::IRQ_REATTACH] = 1'b1;
                end else begin
                    st_nxt.detCnt = st_r.detCnt + 32'h1;
                end
            end
            bbd_pkg::BBD_DEFAULT: begin
                // rearm once the trigger is released or the enable is cleared, so one failure gives one detach
                if (trigLevel || !enabled) begin
                    st_nxt.mode = bbd_pkg::BBD_IDLE;
                end
            end
        endcase

        // register writes
        if (regWrite) begin
            unique case (regAddr)
                bbd_pkg::TIMEOUT_A_LOW_OFS:  st_nxt.toALow  = regWrData;
                bbd_pkg::TIMEOUT_A_HIGH_OFS: st_nxt.toAHigh = regWrData;
                bbd_pkg::TIMEOUT_B_LOW_OFS:  st_nxt.toBLow  = regWrData;
                bbd_pkg::TIMEOUT_B_HIGH_OFS: st_nxt.toBHigh = regWrData;
                bbd_pkg::CONTROL_OFS:        st_nxt.control = {2'b00, regWrData[5:0]};
                bbd_pkg::IRQ_MASK_OFS:       st_nxt.irqMask = regWrData[3:0];
                default: begin
                    if (descIdx < 16'(bbd_pkg::DESC_LEN)) begin
                        st_nxt.desc[descIdx[5:0]] = regWrData;
                    end
                end
            endcase
        end

        // reads; unmapped reads answer zero
        st_nxt.rdData = 8'h00;
        if (regRead) begin
            unique case (regAddr)
                bbd_pkg::TIMEOUT_A_LOW_OFS:  st_nxt.rdData = st_r.toALow;
                bbd_pkg::TIMEOUT_A_HIGH_OFS: st_nxt.rdData = st_r.toAHigh;
                bbd_pkg::TIMEOUT_B_LOW_OFS:  st_nxt.rdData = st_r.toBLow;
                bbd_pkg::TIMEOUT_B_HIGH_OFS: st_nxt.rdData = st_r.toBHigh;
                bbd_pkg::CONTROL_OFS:        st_nxt.rdData = st_r.control;
                bbd_pkg::STATUS_OFS:
                    st_nxt.rdData = {3'h0, runB, runA, st_r.mode};
                bbd_pkg::IRQ_STATUS_OFS:     st_nxt.rdData = {4'h0, st_r.irqStat};
                bbd_pkg::IRQ_MASK_OFS:       st_nxt.rdData = {4'h0, st_r.irqMask};
                default: begin
                    if (descIdx < 16'(bbd_pkg::DESC_LEN)) begin
                        st_nxt.rdData = st_r.desc[descIdx[5:0]];
                    end
                end
            endcase
        end

        // read clears status; a new event in the same cycle survives
        if (regRead && regAddr == bbd_pkg::IRQ_STATUS_OFS) begin
            st_nxt.irqStat = ev;
        end else begin
            st_nxt.irqStat = st_r.irqStat | ev;
        end
        st_nxt.irq = |(st_nxt.irqStat & st_nxt.irqMask);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= rstVal;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData     = st_r.rdData;
    assign connectOut    = st_r.connect;
    assign billboardMode = st_r.bbMode;
    assign irqOut        = st_r.irq;
endmodule
`default_nettype wire

/* dv/bbd_detach_timers_asserts.sv */
`default_nettype none
module bbd_detach_timers_asserts #(
    parameter int STEP_CYCLES   = 20,
    parameter int DETACH_CYCLES = 5
) (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [15:0] regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regRdData,
    input wire logic        triggerN,
    input wire logic        addressSet,
    input wire logic        altStringReq,
    input wire logic        connectOut,
    input wire logic        billboardMode,
    input wire logic        irqOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       enable_r;
    logic       started_r;
    logic       default_r;
    logic [7:0] mask_r;
    // shadows of register and mode state, since the checker cannot see inside
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            enable_r  <= 1'b0;
            started_r <= 1'b0;
            default_r <= 1'b0;
            mask_r    <= 8'h00;
        end else begin
            if (regWrite && regAddr == bbd_pkg::CONTROL_OFS) enable_r <= regWrData[0];
            if (regWrite && regAddr == bbd_pkg::IRQ_MASK_OFS) mask_r <= regWrData;
            if (!billboardMode) started_r <= 1'b0;
            else if ((addressSet || altStringReq) && connectOut) started_r <= 1'b1;
            // raw pin is ahead of the synchroniser, so this clears early: safe side
            if (triggerN || !enable_r) default_r <= 1'b0;
            else if ($rose(connectOut) && !billboardMode) default_r <= 1'b1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence detachLow;
        !connectOut [*4];
    endsequence
    chk_rd_idle_zero: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data not zero outside read answer");
    chk_rsvd_read_zero: assert property ($past(regRead) && $past(regAddr) ==
        bbd_pkg::CONTROL_OFS |-> regRdData[7:6] == 2'b00)
        else $error("control reserved bits read nonzero");
    chk_trig_gate: assert property ($fell(connectOut) && !$past(billboardMode)
        |-> $past(enable_r) && !($past(triggerN, 4) && $past(triggerN, 5)))
        else $error("detach without enable and low trigger");
    chk_bb_attach: assert property ($fell(connectOut) && !$past(billboardMode)
        |-> detachLow ##[1:4] (connectOut && billboardMode))
        else $error("billboard attach missing");
    chk_bb_exit: assert property ($fell(connectOut) && $past(billboardMode)
        |-> detachLow ##[1:4] (connectOut && !billboardMode))
        else $error("default reattach missing");
    chk_detach_cause: assert property ($fell(connectOut) && $past(billboardMode)
        |-> $past(started_r) || !$past(enable_r))
        else $error("billboard detach without timer start");
    chk_no_second: assert property (default_r |-> connectOut)
        else $error("second detach after default reattach");
    // only the low four mask bits exist in the design
    chk_irq_masked: assert property (irqOut |-> mask_r[3:0] != 4'h0)
        else $error("interrupt with all sources masked");
endmodule
bind bbd_detach_timers bbd_detach_timers_asserts #(
    .STEP_CYCLES(STEP_CYCLES),
    .DETACH_CYCLES(DETACH_CYCLES)
) u_chk (.mclk, .sys_rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .triggerN, .addressSet, .altStringReq, .connectOut, .billboardMode, .irqOut);
`default_nettype wire

/* dv/bbd_host_model.sv */
`default_nettype none
module bbd_host_model (
    input  wire logic mclk,
    input  wire logic connectOut,
    input  wire logic billboardMode,
    output logic      triggerN,
    output logic      addressSet,
    output logic      altStringReq
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        triggerN = 1'b1;
        addressSet = 1'b0;
        altStringReq = 1'b0;
    end
    // pd controller holds the line low as long as the failure lasts
    task automatic alt_fail(input logic failed);
        @(posedge mclk);
        triggerN <= !failed;
    endtask
    // host only talks to an attached billboard; delay models a slow host
    task automatic enumerate(input logic strReq, input int delay);
        repeat (delay) @(posedge mclk);
        // look after the edge has settled, not in the edge's own time step
        #1;
        if (connectOut && billboardMode) begin
            @(posedge mclk);
            if (strReq) altStringReq <= 1'b1;
            else addressSet <= 1'b1;
            @(posedge mclk);
            altStringReq <= 1'b0;
            addressSet <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* dv/bbd_detach_timers_tb_top.sv */
`default_nettype none
module bbd_detach_timers_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 20;
    localparam int DET = 5;
    logic        mclk = 1'b0;
    logic        sys_rst;
    logic [15:0] regAddr;
    logic [7:0]  regWrData;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regRdData;
    logic        triggerN;
    logic        addressSet;
    logic        altStringReq;
    logic        connectOut;
    logic        billboardMode;
    logic        irqOut;
    int          n_mismatch = 0;
    int          compares = 0;
    int          n;
    int          descIdx[7] = '{0, 3, 4, 7, 40, 41, 45};
    logic [7:0]  descVal[7] = '{8'h00, 8'h01, 8'h01, 8'h80, 8'h10, 8'h01, 8'hff};
    always #4 mclk = ~mclk;
    bbd_detach_timers #(.STEP_CYCLES(STEP), .DETACH_CYCLES(DET)) uut (.mclk, .sys_rst,
        .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .triggerN, .addressSet,
        .altStringReq, .connectOut, .billboardMode, .irqOut);
    bbd_host_model host (.mclk, .connectOut, .billboardMode, .triggerN, .addressSet,
        .altStringReq);
    task automatic test_done;
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 cmp8(regRdData & m, exp);
    endtask
    task automatic set_timers(input logic [15:0] ta, input logic [15:0] tb);
        wr(bbd_pkg::TIMEOUT_A_LOW_OFS, ta[7:0]);
        wr(bbd_pkg::TIMEOUT_A_HIGH_OFS, ta[15:8]);
        wr(bbd_pkg::TIMEOUT_B_LOW_OFS, tb[7:0]);
        wr(bbd_pkg::TIMEOUT_B_HIGH_OFS, tb[15:8]);
    endtask
    // bounded wait on the attach level; running out shows as a mismatch
    task automatic await(input logic c, input int lim, output int cnt);
        cnt = 0;
        while (connectOut !== c && cnt < lim) begin
            @(posedge mclk);
            #1 cnt++;
        end
        cmp8({7'h0, connectOut}, {7'h0, c});
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        test_done();
    end
    initial begin
        sys_rst = 1'b1;
        regAddr = 16'h0000;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) rdc(bbd_pkg::TIMEOUT_A_LOW_OFS + 16'(i), 8'hff,
            i[0] ? 8'h07 : 8'hd0);
        rdc(bbd_pkg::CONTROL_OFS, 8'hff, 8'h14);
        for (int i = 0; i < 7; i++) rdc(bbd_pkg::DESC_BASE_OFS + 16'(descIdx[i]), 8'hff,
            descVal[i]);
        wr(bbd_pkg::DESC_BASE_OFS + 16'h0003, 8'h5a);
        rdc(bbd_pkg::DESC_BASE_OFS + 16'h0003, 8'hff, 8'h5a);
        rdc(16'h4000, 8'hff, 8'h00);
        host.alt_fail(1'b1);
        repeat (30) @(posedge mclk);
        #1 cmp8({7'h0, connectOut}, 8'h01);
        wr(bbd_pkg::CONTROL_OFS, 8'hd5);
        rdc(bbd_pkg::CONTROL_OFS, 8'hff, 8'h15);
        await(1'b0, 20, n);
        await(1'b1, DET + 8, n);
        cmp8({7'h0, billboardMode}, 8'h01);
        // b is shorter and started later, so it must win
        set_timers(16'h0003, 16'h0001);
        host.enumerate(1'b0, 0);
        host.enumerate(1'b1, 2);
        await(1'b0, 4 * STEP, n);
        cmp8({7'h0, n <= STEP + 4}, 8'h01);
        rdc(bbd_pkg::IRQ_STATUS_OFS, 8'h06, 8'h04);
        await(1'b1, DET + 8, n);
        cmp8({7'h0, billboardMode}, 8'h00);
        repeat (4 * STEP) @(posedge mclk);
        #1 cmp8({7'h0, connectOut}, 8'h01);
        // a high byte of one makes a 258 step timeout
        wr(bbd_pkg::IRQ_MASK_OFS, 8'h02);
        set_timers(16'h0102, 16'hffff);
        host.alt_fail(1'b0);
        repeat (10) @(posedge mclk);
        host.alt_fail(1'b1);
        await(1'b0, 20, n);
        await(1'b1, DET + 8, n);
        host.enumerate(1'b0, 3);
        // timer a running, billboard mode
        rdc(bbd_pkg::STATUS_OFS, 8'hff, 8'h0a);
        await(1'b0, 260 * STEP, n);
        cmp8({7'h0, n >= 257 * STEP - 2 && n <= 258 * STEP + 8}, 8'h01);
        await(1'b1, DET + 8, n);
        cmp8({6'h0, irqOut, billboardMode}, 8'h02);
        rdc(bbd_pkg::IRQ_STATUS_OFS, 8'h06, 8'h02);
        repeat (2) @(posedge mclk);
        #1 cmp8({7'h0, irqOut}, 8'h00);
        // clearing the enable in billboard mode forces the default reattach
        host.alt_fail(1'b0);
        repeat (10) @(posedge mclk);
        host.alt_fail(1'b1);
        await(1'b0, 20, n);
        await(1'b1, DET + 8, n);
        rdc(bbd_pkg::STATUS_OFS, 8'hff, 8'h02);
        wr(bbd_pkg::CONTROL_OFS, 8'h14);
        await(1'b0, 8, n);
        await(1'b1, DET + 8, n);
        cmp8({7'h0, billboardMode}, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
